// ### logic/pmwc_pkg.sv
package pmwc_pkg;
	// ==========================================
	// Register map (byte addresses)
	localparam logic [7:0] ADDR_PROG_CLK_SW = 8'h04;
	localparam logic [7:0] ADDR_GATE_CTRL   = 8'h06;
	localparam logic [7:0] ADDR_MODE_STAT   = 8'h10;
	localparam logic [7:0] ADDR_WAKE_EN     = 8'h14;
	// ==========================================
	// Programming clock switch fields
	localparam int PCS_PROG_EN_BIT   = 7;
	localparam int PCS_SER_EN_BIT    = 5;
	localparam int PCS_FLAG_BIT      = 4;
	localparam int PCS_DET_RST_BIT   = 1;
	localparam int PCS_FIX_RST_BIT   = 0;
	localparam logic [7:0] PCS_RESET = 8'h00;
	// ==========================================
	// Gate control fields
	localparam logic [3:0] GATE_KEY   = 4'h5;
	localparam int GATE_CPU_BIT       = 3;
	localparam int GATE_SYS_BIT       = 2;
	localparam int GATE_SRC_BIT       = 1;
	localparam int GATE_FRC_BIT       = 0;
	localparam logic [3:0] GATE_RESET = 4'h0;
	// ==========================================
	// Source clock selection
	localparam logic [1:0] SRC_FAST_RC  = 2'b00;
	localparam logic [1:0] SRC_CRYSTAL  = 2'b01;
	localparam logic [1:0] SRC_SLOW_RC  = 2'b10;
	// ==========================================
	// Wake delays in source clock periods, then GPIO pin and IRQ line counts
	localparam int IDLE_WAKE_CLKS   = 2;
	localparam int SLEEP1_WAKE_CLKS = 8;
	localparam int SLEEP2_RC_CLKS   = 128;
	localparam int SLEEP2_XTAL_CLKS = 16 * 1024;
	localparam int GPIO_PINS        = 18;
	localparam int IRQ_LINES        = 16;
	// ==========================================
	// Power mode states
	typedef enum logic [2:0] {
		PMWC_RUN    = 3'b000,
		PMWC_IDLE1  = 3'b001,
		PMWC_IDLE2  = 3'b010,
		PMWC_SLEEP1 = 3'b011,
		PMWC_SLEEP2 = 3'b100,
		PMWC_WAKE   = 3'b101
	} pmwc_mode_e;
endpackage

// ### logic/pmwc_wake_timer.sv
`timescale 1ns/1ns
module pmwc_wake_timer #(
	parameter int WIDTH = 15
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic             start,
	input  wire logic [WIDTH-1:0] count,
	output logic                  done
);
	logic [WIDTH-1:0] remain;
	logic             busy;
	wire              last = busy && (remain == {{(WIDTH-1){1'b0}}, 1'b1});

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			remain <= '0;
			busy   <= 1'b0;
			done   <= 1'b0;
		end else begin
			done <= last;
			if (start) begin
				remain <= count;
				busy   <= 1'b1;
			end else if (busy) begin
				remain <= remain - 1'b1;
				busy   <= !last;
			end
		end
	end
endmodule

// ### logic/pmwc_top.sv
// Operation
// - CPU gate bit enters Idle 1; only CPU clock stops, widest wake set.
// - System gate bit enters Idle 2; peripheral clock stops, only pin toggle and LVD interrupts wake.
// - Idle modes resume two source clocks after a wake event.
// - Fast RC stop enters Sleep 1 only on fast RC; wake after 8 clocks.
// - Source stop bit enters Sleep 2; RC source wakes after 128 clocks.
// - Sleep 2 on crystal waits 16 times 1024 clocks before resuming.
// - Wake sources allowed per mode follow the fixed mode table.
// - GPIO wake and pin toggle cover only the 18 port pins.
// - External interrupt request lines never wake any mode.
// - Converter wake fires when the selected comparison result toggles.
// - Programming enable plus green or sleep lets programming pin start fast RC.
// - Serial enable lets serial pin activity switch to fast RC.
// - Programming wake sets flag, forces fast RC; clearing enable clears flag.
// - Two read-only bits show raw low supply detection levels.
// - Slow RC system with full-rate crystal watch timer may miss events.
// - Normal 2 uses the crystal to calibrate the fast RC.
// - Gate control writes land only when upper nibble equals the key.
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ns
module pmwc_top #(
	parameter int XTAL_WAKE_CLKS = pmwc_pkg::SLEEP2_XTAL_CLKS
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [1:0]  source_select,
	input  wire logic        green_mode,
	input  wire logic        normal2_mode,
	input  wire logic        reset_pin,
	input  wire logic [17:0] gpio_pin,
	input  wire logic        pin_toggle_interrupt,
	input  wire logic        lvd_interrupt,
	input  wire logic        spi_interrupt,
	input  wire logic        twi_interrupt,
	input  wire logic        comp_interrupt,
	input  wire logic        etimer_interrupt,
	input  wire logic        conv_interrupt,
	input  wire logic        wtmr_interrupt,
	input  wire logic [15:0] ext_irq,
	input  wire logic        conv_compare,
	input  wire logic        comparator_wake,
	input  wire logic        watch_timer_wake,
	input  wire logic        prog_pin,
	input  wire logic        serial_receive_pin,
	input  wire logic        supply_below_detect,
	input  wire logic        supply_below_fixed,
	output logic             cpu_clk_en,
	output logic             sys_clk_en,
	output logic             source_clk_en,
	output logic             fast_rc_on,
	output logic             force_fast_rc,
	output logic             prog_clk_fast_rc,
	output logic             calibrate_fast_rc
);
	// ==========================================
	// Register state
	logic                   prog_en;
	logic                   ser_en;
	logic                   prog_wake_flag;
	logic [3:0]             gate;
	logic [17:0]            gpio_wake_enable;
	logic                   conv_prev;
	logic                   prog_prev;
	logic                   ser_prev;
	pmwc_pkg::pmwc_mode_e   mode;
	logic                   start_timer;
	logic [14:0]            timer_count;
	logic                   timer_done;
	logic                   aw_held;
	logic                   w_held;
	logic [7:0]             aw_addr;
	logic [31:0]            w_data;
	logic [3:0]             w_strb;

	// ==========================================
	// Wake qualification
	wire sleeping   = mode == pmwc_pkg::PMWC_SLEEP1 || mode == pmwc_pkg::PMWC_SLEEP2;
	// Only the 18 port pins exist, so no other GPIO pin can wake
	wire gpio_wake  = |(gpio_pin & gpio_wake_enable);
	wire conv_wake  = conv_compare ^ conv_prev;
	// Interrupt lines ext_irq are deliberately unused
	wire all_wake   = reset_pin | gpio_wake | pin_toggle_interrupt | lvd_interrupt
	                | conv_wake | comparator_wake | watch_timer_wake;
	wire idle1_wake = spi_interrupt | twi_interrupt | comp_interrupt | etimer_interrupt;
	wire prog_act   = prog_pin ^ prog_prev;
	wire prog_trig  = prog_en && prog_act && (green_mode || sleeping);
	wire wake_ok    = (mode == pmwc_pkg::PMWC_IDLE1 && (all_wake || idle1_wake))
	                || (mode == pmwc_pkg::PMWC_IDLE2 && all_wake)
	                || (sleeping && (all_wake || prog_trig));
	// Converter and watch timer interrupts never wake
	// Wake levels sampled per aclk, so faster watch timer events are lost
	wire unused_irq = conv_interrupt | wtmr_interrupt | (|ext_irq);

	// ==========================================
	// Bus decode
	wire do_write  = aw_held && w_held && !s_axi_bvalid;
	wire gate_hit  = do_write && aw_addr == pmwc_pkg::ADDR_GATE_CTRL && w_strb[0];
	wire key_ok    = w_data[7:4] == pmwc_pkg::GATE_KEY;
	wire gate_wr   = gate_hit && key_ok && mode == pmwc_pkg::PMWC_RUN;
	wire pcs_wr    = do_write && aw_addr == pmwc_pkg::ADDR_PROG_CLK_SW && w_strb[0];
	wire wen_wr    = do_write && aw_addr == pmwc_pkg::ADDR_WAKE_EN;
	wire wr_mapped = aw_addr == pmwc_pkg::ADDR_GATE_CTRL || aw_addr == pmwc_pkg::ADDR_PROG_CLK_SW
	               || aw_addr == pmwc_pkg::ADDR_WAKE_EN || aw_addr == pmwc_pkg::ADDR_MODE_STAT;
	wire [7:0] pcs_val = {prog_en, 1'b0, ser_en, prog_wake_flag, 2'b00,
	                      supply_below_detect, supply_below_fixed};
	wire rd_go     = s_axi_arvalid && s_axi_arready;
	wire [31:0] rd_mux =
		s_axi_araddr == pmwc_pkg::ADDR_PROG_CLK_SW ? {24'h00_0000, pcs_val} :
		s_axi_araddr == pmwc_pkg::ADDR_GATE_CTRL   ? {24'h00_0000, pmwc_pkg::GATE_KEY, gate} :
		s_axi_araddr == pmwc_pkg::ADDR_MODE_STAT   ? {29'h0000_0000, mode} :
		s_axi_araddr == pmwc_pkg::ADDR_WAKE_EN     ? {14'h0000, gpio_wake_enable} : 32'h0000_0000;
	wire rd_mapped = s_axi_araddr == pmwc_pkg::ADDR_PROG_CLK_SW
	               || s_axi_araddr == pmwc_pkg::ADDR_GATE_CTRL
	               || s_axi_araddr == pmwc_pkg::ADDR_MODE_STAT
	               || s_axi_araddr == pmwc_pkg::ADDR_WAKE_EN;

	// ==========================================
	// Mode entry and wake delay selection
	wire fast_src   = source_select == pmwc_pkg::SRC_FAST_RC;
	wire [14:0] sleep2_clks = source_select == pmwc_pkg::SRC_CRYSTAL ? 15'(XTAL_WAKE_CLKS)
	                        : 15'(pmwc_pkg::SLEEP2_RC_CLKS);
	wire [14:0] wake_clks = mode == pmwc_pkg::PMWC_SLEEP1 ? 15'(pmwc_pkg::SLEEP1_WAKE_CLKS)
	                      : mode == pmwc_pkg::PMWC_SLEEP2 ? sleep2_clks
	                      : 15'(pmwc_pkg::IDLE_WAKE_CLKS);
	// Sleep 1 is refused unless fast RC is the source
	wire [3:0] next_gate  = {w_data[3:2], w_data[1], w_data[0] & fast_src};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode        <= pmwc_pkg::PMWC_RUN;
			gate        <= pmwc_pkg::GATE_RESET;
			start_timer <= 1'b0;
			timer_count <= '0;
		end else begin
			start_timer <= 1'b0;
			unique case (mode)
				pmwc_pkg::PMWC_RUN: begin
					if (gate_wr) begin
						gate <= next_gate;
						// Priority: deepest requested gate wins
						if (next_gate[pmwc_pkg::GATE_SRC_BIT])
							mode <= pmwc_pkg::PMWC_SLEEP2;
						else if (next_gate[pmwc_pkg::GATE_FRC_BIT])
							mode <= pmwc_pkg::PMWC_SLEEP1;
						else if (next_gate[pmwc_pkg::GATE_SYS_BIT])
							mode <= pmwc_pkg::PMWC_IDLE2;
						else if (next_gate[pmwc_pkg::GATE_CPU_BIT])
							mode <= pmwc_pkg::PMWC_IDLE1;
					end
				end
				pmwc_pkg::PMWC_IDLE1, pmwc_pkg::PMWC_IDLE2,
				pmwc_pkg::PMWC_SLEEP1, pmwc_pkg::PMWC_SLEEP2: begin
					if (wake_ok) begin
						start_timer <= 1'b1;
						timer_count <= wake_clks;
						gate        <= pmwc_pkg::GATE_RESET;
						mode        <= pmwc_pkg::PMWC_WAKE;
					end
				end
				pmwc_pkg::PMWC_WAKE: begin
					if (timer_done)
						mode <= pmwc_pkg::PMWC_RUN;
				end
				default: mode <= pmwc_pkg::PMWC_RUN;
			endcase
		end
	end

	pmwc_wake_timer #(
		.WIDTH (15)
	) u_timer (
		.aclk    (aclk),
		.aresetn (aresetn),
		.start   (start_timer),
		.count   (timer_count),
		.done    (timer_done)
	);

	// ==========================================
	// Programming clock switch register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prog_en          <= pmwc_pkg::PCS_RESET[pmwc_pkg::PCS_PROG_EN_BIT];
			ser_en           <= pmwc_pkg::PCS_RESET[pmwc_pkg::PCS_SER_EN_BIT];
			prog_wake_flag   <= pmwc_pkg::PCS_RESET[pmwc_pkg::PCS_FLAG_BIT];
			gpio_wake_enable <= '0;
			conv_prev        <= 1'b0;
			prog_prev        <= 1'b0;
			ser_prev         <= 1'b0;
			force_fast_rc    <= 1'b0;
			prog_clk_fast_rc <= 1'b0;
		end else begin
			conv_prev <= conv_compare;
			prog_prev <= prog_pin;
			ser_prev  <= serial_receive_pin;
			if (pcs_wr) begin
				prog_en <= w_data[pmwc_pkg::PCS_PROG_EN_BIT];
				ser_en  <= w_data[pmwc_pkg::PCS_SER_EN_BIT];
			end
			if (wen_wr)
				gpio_wake_enable <= w_data[17:0];
			// Set wins over clear so a trigger in the write cycle is kept
			if (prog_trig) begin
				prog_wake_flag <= 1'b1;
				force_fast_rc  <= 1'b1;
			end else if (pcs_wr && !w_data[pmwc_pkg::PCS_PROG_EN_BIT]) begin
				prog_wake_flag <= 1'b0;
				force_fast_rc  <= 1'b0;
			end
			if (ser_en && (serial_receive_pin ^ ser_prev))
				prog_clk_fast_rc <= 1'b1;
			else if (pcs_wr && !w_data[pmwc_pkg::PCS_SER_EN_BIT])
				prog_clk_fast_rc <= 1'b0;
		end
	end

	// ==========================================
	// Clock enables
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cpu_clk_en        <= 1'b1;
			sys_clk_en        <= 1'b1;
			source_clk_en     <= 1'b1;
			fast_rc_on        <= 1'b1;
			calibrate_fast_rc <= 1'b0;
		end else begin
			// CPU held off through the wake delay as well
			cpu_clk_en    <= mode == pmwc_pkg::PMWC_RUN && !gate_wr;
			sys_clk_en    <= mode == pmwc_pkg::PMWC_RUN || mode == pmwc_pkg::PMWC_IDLE1
			              || mode == pmwc_pkg::PMWC_WAKE;
			source_clk_en <= mode != pmwc_pkg::PMWC_SLEEP2 || prog_trig;
			fast_rc_on    <= (mode != pmwc_pkg::PMWC_SLEEP1 && mode != pmwc_pkg::PMWC_SLEEP2)
			              || prog_trig || force_fast_rc;
			calibrate_fast_rc <= normal2_mode;
		end
	end

	// ==========================================
	// AXI4-Lite slave
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= '0;
			w_data        <= '0;
			w_strb        <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'b00;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rresp   <= 2'b00;
			s_axi_rdata   <= '0;
		end else begin
			s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
			s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_mapped ? 2'b00 : 2'b10;
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
			end else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_mux;
				s_axi_rresp  <= rd_mapped ? 2'b00 : 2'b10;
			end else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end
endmodule

// ### dv/pmwc_props.sv
`timescale 1ns/1ns
module pmwc_props (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        normal2_mode,
	input wire logic        spi_interrupt,
	input wire logic        cpu_clk_en,
	input wire logic        sys_clk_en,
	input wire logic        source_clk_en,
	input wire logic        fast_rc_on,
	input wire logic        calibrate_fast_rc
);
	// ==========================================
	// Gate relations and bus handshake
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	property p_sys_off;
		!sys_clk_en |-> !cpu_clk_en;
	endproperty
	a_sys_off: assert property (p_sys_off) else $error("cpu on, sys off");
	property p_src_off;
		!source_clk_en |-> !cpu_clk_en && !sys_clk_en;
	endproperty
	a_src_off: assert property (p_src_off) else $error("clock on, src off");
	property p_frc_off;
		!fast_rc_on |-> !cpu_clk_en;
	endproperty
	a_frc_off: assert property (p_frc_off) else $error("cpu on, fast rc off");
	// Other wakes may overlap, so only the upper bound is tight
	property p_idle_wake;
		$rose(spi_interrupt) && !cpu_clk_en && sys_clk_en |-> ##[3:6] cpu_clk_en;
	endproperty
	a_idle_wake: assert property (p_idle_wake) else $error("idle wake late");
	property p_irq_ignored;
		$rose(spi_interrupt) && !sys_clk_en |-> ##1 !cpu_clk_en [*4];
	endproperty
	a_irq_ignored: assert property (p_irq_ignored) else $error("irq woke");
	property p_rvalid;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rvalid: assert property (p_rvalid) else $error("read dropped");
	property p_bvalid;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_bvalid: assert property (p_bvalid) else $error("write resp dropped");
	property p_awready;
		s_axi_awready |=> !s_axi_awready;
	endproperty
	a_awready: assert property (p_awready) else $error("awready held");
	property p_calib;
		calibrate_fast_rc |-> $past(normal2_mode);
	endproperty
	a_calib: assert property (p_calib) else $error("calibrating off mode");
endmodule
bind pmwc_top pmwc_props u_pmwc_props (.*);

// ### dv/pmwc_wake_src.sv
`timescale 1ns/1ns
module pmwc_wake_src (
	input  wire logic        aclk,
	input  wire logic        fire,
	input  wire logic [3:0]  sel,
	output logic      [13:0] src,
	output logic             conv_compare
);
	// ==========================================
	// Lines hold four cycles, then pulled low
	logic [1:0] hold;
	initial begin
		src = 14'h0000;
		conv_compare = 1'b0;
		hold = 2'h0;
	end
	always @(posedge aclk) begin
		if (fire) begin
			src <= 14'h0001 << sel;
			hold <= 2'h3;
			if (sel == 4'hC)
				conv_compare <= ~conv_compare; // Toggle, not level
		end else if (hold != 2'h0)
			hold <= hold - 2'h1;
		else
			src <= 14'h0000;
	end
endmodule

// ### dv/tb.sv
`timescale 1ns/1ns
module tb;
	// ==========================================
	// Signals
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic        s_axi_rready, green_mode, normal2_mode, reset_pin, pin_toggle_interrupt;
	logic        lvd_interrupt, spi_interrupt, twi_interrupt, comp_interrupt, etimer_interrupt;
	logic        conv_interrupt, wtmr_interrupt, conv_compare, comparator_wake, watch_timer_wake;
	logic        prog_pin, serial_receive_pin, supply_below_detect, supply_below_fixed;
	logic        cpu_clk_en, sys_clk_en, source_clk_en, fast_rc_on, force_fast_rc;
	logic        prog_clk_fast_rc, calibrate_fast_rc, fire;
	logic [1:0]  s_axi_bresp, s_axi_rresp, source_select;
	logic [3:0]  s_axi_wstrb, sel;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [13:0] src, allow;
	logic [15:0] ext_irq, irq_val;
	logic [17:0] gpio_pin;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [33:0] expq[$];
	int          failures = 0, num_checks = 0, seed = 82010, gsel, n, lat;
	int          wk[4] = '{2, 2, 128, 8};
	logic [33:0] mc[4] = '{34'h1, 34'h2, 34'h4, 34'h3};
	logic [33:0] ce[4] = '{34'h7, 34'h3, 34'h0, 34'h2};
	localparam logic [7:0] A_SW   = pmwc_pkg::ADDR_PROG_CLK_SW;
	localparam logic [7:0] A_GATE = pmwc_pkg::ADDR_GATE_CTRL;
	localparam logic [7:0] A_MODE = pmwc_pkg::ADDR_MODE_STAT;
	localparam logic [7:0] A_WAKE = pmwc_pkg::ADDR_WAKE_EN;
	// Watch timer wake assumes its sub oscillator already runs
	assign {watch_timer_wake, comparator_wake, wtmr_interrupt, conv_interrupt, etimer_interrupt,
		comp_interrupt, twi_interrupt, spi_interrupt, lvd_interrupt, pin_toggle_interrupt} = src[11:2];
	assign reset_pin = src[0];
	assign gpio_pin  = src[1] ? 18'h0_0001 << gsel : 18'h0_0000;
	assign ext_irq   = src[13] ? irq_val : 16'h0000;
	pmwc_top #(.XTAL_WAKE_CLKS(20)) u_pmwc_top (.*);
	pmwc_wake_src u_pmwc_wake_src (.*);
	always #4 aclk = ~aclk;
	// ==========================================
	// Checking
	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic stop_test;
		if (failures == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic give_up;
		failures++;
		stop_test();
	endtask
	// Responses land in order, one transfer at a time
	always @(posedge aclk) begin
		if (s_axi_rvalid && s_axi_rready)
			chk({s_axi_rresp, s_axi_rdata}, expq.pop_front());
		else if (s_axi_bvalid && s_axi_bready)
			chk({s_axi_bresp, 32'h0000_0000}, expq.pop_front());
	end
	// ==========================================
	// Bus and wake drivers
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		expq.push_back(34'h0);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 500 && s_axi_bvalid !== 1'b1; n++) begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		if (n >= 500)
			give_up();
		@(posedge aclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		expq.push_back(e);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 500 && s_axi_rvalid !== 1'b1; n++) begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		if (n >= 500)
			give_up();
		@(posedge aclk);
	endtask
	task automatic wake_wait;
		for (lat = 0; lat < 300 && cpu_clk_en !== 1'b1; lat++)
			@(posedge aclk);
	endtask
	task automatic fire_src(input logic [3:0] s);
		gsel <= $unsigned($random(seed)) % 18;
		irq_val <= 16'($random(seed));
		fire <= 1'b1;
		sel <= s;
		@(posedge aclk);
		fire <= 1'b0;
		wake_wait();
	endtask
	// ==========================================
	// Main sequence
	initial begin
		aclk = 1'b0;
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{fire, sel, source_select, green_mode, normal2_mode} = 9'h000;
		{prog_pin, serial_receive_pin, supply_below_detect, supply_below_fixed} = 4'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0000_0000_0000;
		gsel = 0;
		irq_val = 16'h0000;
		s_axi_wstrb = 4'hF;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(A_SW, 34'h0);
		rd(A_GATE, 34'h50);
		rd(8'h20, 34'h2_0000_0000);
		wr(A_GATE, 32'h0000_0038);
		rd(A_GATE, 34'h50);
		wr(A_WAKE, 32'hFFFF_FFFF);
		rd(A_WAKE, 34'h3_FFFF);
		source_select <= 2'b10;
		wr(A_GATE, 32'h0000_0051);
		rd(A_MODE, 34'h0);
		source_select <= 2'b00;
		for (int m = 0; m < 4; m++) begin
			allow = (m == 0) ? 14'h1CFF : 14'h1C0F;
			for (int s = 0; s < 14; s++) begin
				wr(A_GATE, 32'h50 | (32'h1 << (3 - m)));
				rd(A_MODE, mc[m]);
				chk({31'h0, sys_clk_en, source_clk_en, fast_rc_on}, ce[m]);
				fire_src(4'(s));
				if (allow[s]) begin
					chk(34'(lat >= wk[m] + 2 && lat <= wk[m] + 5), 34'h1);
				end else begin
					chk(34'(cpu_clk_en), 34'h0);
					rd(A_GATE, 34'h50 | (34'h1 << (3 - m)));
					fire_src(4'h0);
				end
				rd(A_GATE, 34'h50);
			end
		end
		source_select <= 2'b01;
		wr(A_GATE, 32'h0000_0052);
		fire_src(4'h0);
		chk(34'(lat >= 22 && lat <= 25), 34'h1);
		source_select <= 2'b00;
		wr(A_SW, 32'h0000_00A0);
		rd(A_SW, 34'hA0);
		wr(A_GATE, 32'h0000_0052);
		prog_pin <= 1'b1;
		wake_wait();
		chk(34'(lat < 300), 34'h1);
		rd(A_SW, 34'hB0);
		chk(34'(force_fast_rc), 34'h1);
		wr(A_SW, 32'h0000_0020);
		rd(A_SW, 34'h20);
		serial_receive_pin <= 1'b1;
		for (n = 0; n < 50 && prog_clk_fast_rc !== 1'b1; n++)
			@(posedge aclk);
		chk(34'(prog_clk_fast_rc), 34'h1);
		wr(A_SW, 32'h0000_0000);
		serial_receive_pin <= 1'b0;
		repeat (4) @(posedge aclk);
		chk(34'(prog_clk_fast_rc), 34'h0);
		// Programming pin activity counts only in green or sleep
		wr(A_SW, 32'h0000_0080);
		prog_pin <= 1'b0;
		repeat (3) @(posedge aclk);
		rd(A_SW, 34'h80);
		// Green keeps slow RC source; regulator and prescale not modelled
		source_select <= 2'b10;
		green_mode <= 1'b1;
		prog_pin <= 1'b1;
		repeat (3) @(posedge aclk);
		rd(A_SW, 34'h90);
		chk(34'(force_fast_rc), 34'h1);
		green_mode <= 1'b0;
		source_select <= 2'b00;
		wr(A_SW, 32'h0000_0000);
		for (int k = 0; k < 4; k++) begin
			{supply_below_detect, supply_below_fixed} <= 2'(k);
			repeat (3) @(posedge aclk);
			rd(A_SW, 34'(k));
		end
		// Mid-run reset must clear enables but keep raw supply levels
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(A_WAKE, 34'h0);
		rd(A_SW, 34'h3);
		normal2_mode <= 1'b1;
		repeat (4) @(posedge aclk);
		chk(34'(calibrate_fast_rc), 34'h1);
		stop_test();
	end
endmodule
